// ==== src/sie_consts.svh ====
`ifndef SIE_CONSTS_SVH
`define SIE_CONSTS_SVH

// Register byte offsets
`define SIE_CTRL_OFF      8'h00
`define SIE_FILTER_OFF    8'h04
`define SIE_SIMUL_OFF     8'h08
`define SIE_STATUS_OFF    8'h0C

// Control register fields
`define SIE_CTRL_MODE_LSB  0
`define SIE_CTRL_ITYPE_LSB 3
`define SIE_CTRL_RST_EN    6
`define SIE_CTRL_RST_MON   7
`define SIE_CTRL_START_EN  8
`define SIE_CTRL_SIMUL_EN  9
`define SIE_CTRL_ERR_EN    10
`define SIE_CTRL_TEST_EN   11
`define SIE_CTRL_RUN       12
`define SIE_CTRL_W         13

// Reset values
`define SIE_CTRL_RST      13'h0000
`define SIE_FILTER_RST    8'h0A
`define SIE_SIMUL_RST     16'h0064

// Timing
`define SIE_MS_NS         1000000
`define SIE_CLK_NS        40
`define SIE_FILTER_MIN    8'h03
`define SIE_FILTER_MAX    8'hFA
`define SIE_PULSE_PERIOD_MS 100

`endif

// ==== src/sie_pkg.sv ====
package sie_pkg;

  typedef enum logic [2:0] {
    sie_mode_gate    = 3'h0,
    sie_mode_sgate   = 3'h1,
    sie_mode_lock    = 3'h2,
    sie_mode_key     = 3'h3,
    sie_mode_curtain = 3'h4
  } sie_mode_t;

  typedef enum logic [2:0] {
    sie_it_snc  = 3'h0,
    sie_it_dnc  = 3'h1,
    sie_it_ncno = 3'h2,
    sie_it_sno  = 3'h3,
    sie_it_dno  = 3'h4
  } sie_itype_t;

  typedef enum logic [4:0] {
    sie_st_start    = 5'h01,
    sie_st_off      = 5'h02,
    sie_st_wait_rst = 5'h04,
    sie_st_on       = 5'h08,
    sie_st_fault    = 5'h10
  } sie_state_t;

endpackage : sie_pkg

// ==== src/sie_debounce.sv ====
`timescale 1ns/100ps
module sie_debounce #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ms_tick,
  input  wire logic [7:0]   filter_ms,
  input  wire logic [N-1:0] pin,
  output logic      [N-1:0] pin_sync,
  output logic      [N-1:0] filt
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      logic       s1_r;
      logic       s2_r;
      logic       filt_r;
      logic [7:0] cnt_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r   <= 1'b0;
          s2_r   <= 1'b0;
          filt_r <= 1'b0;
          cnt_r  <= 8'h00;
        end else begin
          s1_r <= pin[i];
          s2_r <= s1_r;
          // Output moves only after the new level held over filter_ms consecutive ms ticks
          if (s2_r == filt_r) begin
            cnt_r <= 8'h00;
          end else if (ms_tick) begin
            if (cnt_r + 8'h01 >= filter_ms) begin
              filt_r <= s2_r;
              cnt_r  <= 8'h00;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
      end
      assign pin_sync[i] = s2_r;
      assign filt[i]     = filt_r;
    end
  endgenerate

endmodule : sie_debounce

// ==== src/sie_test_pulse.sv ====
`timescale 1ns/100ps
module sie_test_pulse #(
  parameter int PERIOD_MS = 100,
  parameter int N         = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ms_tick,
  input  wire logic         enable,
  input  wire logic [N-1:0] chan_en,
  input  wire logic [N-1:0] pin_sync,
  output logic      [N-1:0] test_out,
  output logic              short_fault
);

  logic [7:0]   ms_cnt_r;
  logic [N-1:0] out_r;
  logic [N-1:0] short_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= 8'h00;
    end else if (ms_tick) begin
      ms_cnt_r <= (ms_cnt_r == 8'(PERIOD_MS - 1)) ? 8'h00 : ms_cnt_r + 8'h01;
    end
  end

  // Channels are pulsed in separate slots so a short between lines shows up
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      wire pulse_w = enable & chan_en[i] & (ms_cnt_r == 8'(i * PERIOD_MS / N));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_r[i]   <= 1'b1;
          short_r[i] <= 1'b0;
        end else begin
          out_r[i] <= ~pulse_w;
          if (!enable || !chan_en[i]) begin
            short_r[i] <= 1'b0;
          end else if (ms_tick && !out_r[i]) begin
            // A line that stays high during its own low pulse is fed from elsewhere
            short_r[i] <= pin_sync[i];
          end
        end
      end
    end
  endgenerate

  assign test_out    = out_r;
  assign short_fault = |short_r;

endmodule : sie_test_pulse

// ==== src/sie_top.sv ====
`timescale 1ns/100ps
`include "sie_consts.svh"
module sie_top
  import sie_pkg::*;
#(
  parameter int CYCLES_PER_MS   = `SIE_MS_NS / `SIE_CLK_NS,
  parameter int ADDR_W          = 8,
  parameter int PULSE_PERIOD_MS = `SIE_PULSE_PERIOD_MS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              first_contact_input,
  input  wire logic              second_contact_input,
  input  wire logic              reset_input,
  output logic      [1:0]        test_pulse_out,
  output logic                   safe_out,
  output logic                   error_out
);

  localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);

  logic [`SIE_CTRL_W-1:0] ctrl_r;
  logic [7:0]             filter_r;
  logic [15:0]            simul_r;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic [PRE_W-1:0]       pre_r;
  logic                   ms_tick_r;
  logic [15:0]            mis_cnt_r;
  logic                   simul_flt_r;
  logic                   short_flt_r;
  logic                   seen_off_r;
  logic                   rst_prev_r;
  logic                   rst_armed_r;
  logic                   safe_r;
  logic                   err_r;
  sie_state_t             st_r;
  sie_state_t             st_nxt;
  logic [2:0]             pin_sync_w;
  logic [2:0]             filt_w;
  logic [1:0]             test_w;
  logic                   short_w;

  // APB decode
  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable & pready_r;
  wire sel_ctrl = (paddr == ADDR_W'(`SIE_CTRL_OFF));
  wire sel_filt = (paddr == ADDR_W'(`SIE_FILTER_OFF));
  wire sel_sim  = (paddr == ADDR_W'(`SIE_SIMUL_OFF));
  wire sel_stat = (paddr == ADDR_W'(`SIE_STATUS_OFF));
  wire hit_w    = sel_ctrl | sel_filt | sel_sim | sel_stat;
  wire wr_w     = access_w & pwrite;

  // Configuration fields
  wire [2:0] mode_raw  = ctrl_r[`SIE_CTRL_MODE_LSB +: 3];
  wire [2:0] itype_raw = ctrl_r[`SIE_CTRL_ITYPE_LSB +: 3];
  wire rst_en    = ctrl_r[`SIE_CTRL_RST_EN];
  wire rst_mon   = ctrl_r[`SIE_CTRL_RST_MON];
  wire start_en  = ctrl_r[`SIE_CTRL_START_EN];
  wire simul_en  = ctrl_r[`SIE_CTRL_SIMUL_EN];
  wire err_en    = ctrl_r[`SIE_CTRL_ERR_EN];
  wire test_en   = ctrl_r[`SIE_CTRL_TEST_EN];
  wire run_en    = ctrl_r[`SIE_CTRL_RUN];
  wire is_curt   = (mode_raw == sie_mode_curtain);
  wire is_sgate  = (mode_raw == sie_mode_sgate);
  wire it_single = (itype_raw == sie_it_snc) | (itype_raw == sie_it_sno);
  wire it_mixed  = (itype_raw == sie_it_ncno);

  // contact type selection; curtain is always two channels
  wire single_ch = ~is_curt & (is_sgate | it_single);
  // NC contact on the second input reads inverted in the mixed case
  wire inv_b     = ~is_curt & ~is_sgate & it_mixed;
  // curtain checks its own outputs, pulses stay off
  wire pulse_en  = test_en & ~is_curt;
  wire simul_act = ~single_ch & (simul_en | is_curt);

  // filter clamped to its legal span
  wire [7:0] filt_cl = (pwdata[7:0] < `SIE_FILTER_MIN) ? `SIE_FILTER_MIN :
                       (pwdata[7:0] > `SIE_FILTER_MAX) ? `SIE_FILTER_MAX : pwdata[7:0];

  // Normalised channels: 1 means the safe condition on that line
  wire ch_a = filt_w[0];
  wire ch_b = single_ch ? filt_w[0] : (filt_w[1] ^ inv_b);
  wire rst_f = filt_w[2];
  // gate closed, locked, key turned, area clear
  wire cond = ch_a & ch_b;
  wire idle = ~ch_a & ~ch_b;
  wire mis  = ch_a ^ ch_b;

  wire simul_set = simul_act & mis & (mis_cnt_r > simul_r);
  wire short_set = short_w;
  wire clr_ok    = idle & ~short_w;
  wire fault_any = simul_flt_r | short_flt_r;

  // manual reset on rising edge; monitored reset on fall after arming
  wire rst_rise = rst_f & ~rst_prev_r;
  wire rst_fall = ~rst_f & rst_prev_r;
  wire rst_ok   = rst_mon ? (rst_fall & rst_armed_r) : rst_rise;

  wire [31:0] status_w = {20'h0, filt_w[1:0], st_r, seen_off_r, short_flt_r,
                          simul_flt_r, err_r, safe_r};
  wire [31:0] rd_w = sel_ctrl ? {19'h0, ctrl_r} :
                     sel_filt ? {24'h0, filter_r} :
                     sel_sim  ? {16'h0, simul_r} :
                     sel_stat ? status_w : 32'h0;

  sie_debounce #(
    .N (3)
  ) u_deb (
    .pclk      (pclk),
    .presetn   (presetn),
    .ms_tick   (ms_tick_r),
    .filter_ms (filter_r),
    .pin       ({reset_input, second_contact_input, first_contact_input}),
    .pin_sync  (pin_sync_w),
    .filt      (filt_w)
  );

  // pulses only on channels actually wired
  sie_test_pulse #(
    .PERIOD_MS (PULSE_PERIOD_MS),
    .N         (2)
  ) u_tp (
    .pclk        (pclk),
    .presetn     (presetn),
    .ms_tick     (ms_tick_r),
    .enable      (pulse_en),
    .chan_en     ({~single_ch, 1'b1}),
    .pin_sync    (pin_sync_w[1:0]),
    .test_out    (test_w),
    .short_fault (short_w)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      ctrl_r    <= `SIE_CTRL_RST;
      filter_r  <= `SIE_FILTER_RST;
      simul_r   <= `SIE_SIMUL_RST;
    end else begin
      // Zero wait states: answer in the access cycle right after setup
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~hit_w;
      if (setup_w) prdata_r <= pwrite ? 32'h0 : rd_w;
      if (wr_w && sel_ctrl) ctrl_r <= pwdata[`SIE_CTRL_W-1:0];
      if (wr_w && sel_filt) filter_r <= filt_cl;
      if (wr_w && sel_sim) simul_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r     <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (pre_r == PRE_W'(CYCLES_PER_MS - 1));
      pre_r     <= (pre_r == PRE_W'(CYCLES_PER_MS - 1)) ? '0 : pre_r + 1'b1;
    end
  end

  // count how long the channels disagree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mis_cnt_r <= 16'h0;
    end else if (!mis) begin
      mis_cnt_r <= 16'h0;
    end else if (ms_tick_r && mis_cnt_r != 16'hFFFF) begin
      mis_cnt_r <= mis_cnt_r + 16'h1;
    end
  end

  // Fault flags: a new fault wins over the clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simul_flt_r <= 1'b0;
      short_flt_r <= 1'b0;
    end else begin
      simul_flt_r <= simul_set | (simul_flt_r & ~clr_ok);
      short_flt_r <= short_set | (short_flt_r & ~clr_ok);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_off_r  <= 1'b0;
      rst_prev_r  <= 1'b0;
      rst_armed_r <= 1'b0;
    end else begin
      // remember the device was released once after power-on
      if (run_en && !cond) seen_off_r <= 1'b1;
      rst_prev_r <= rst_f;
      if (st_r != sie_st_wait_rst || rst_ok) begin
        rst_armed_r <= 1'b0;
      end else if (rst_rise) begin
        rst_armed_r <= 1'b1;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      sie_st_start: begin
        if (run_en && !fault_any && (!start_en || (seen_off_r && cond)))
          st_nxt = (start_en && !rst_en) ? sie_st_on : sie_st_off;
      end
      sie_st_off: begin
        if (fault_any) st_nxt = sie_st_fault;
        // without reset the output follows the input
        else if (cond) st_nxt = rst_en ? sie_st_wait_rst : sie_st_on;
      end
      sie_st_wait_rst: begin
        if (fault_any) st_nxt = sie_st_fault;
        else if (!cond) st_nxt = sie_st_off;
        else if (rst_ok) st_nxt = sie_st_on;
      end
      sie_st_on: begin
        // a fault drops the output at once
        if (fault_any) st_nxt = sie_st_fault;
        else if (!cond) st_nxt = sie_st_off;
      end
      sie_st_fault: begin
        if (!fault_any) st_nxt = sie_st_off;
      end
      default: st_nxt = sie_st_fault;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= sie_st_start;
      safe_r <= 1'b0;
      err_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      safe_r <= (st_nxt == sie_st_on);
      // error output reflects any latched fault
      err_r  <= err_en & (simul_set | short_set | (fault_any & ~clr_ok));
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign test_pulse_out = test_w;
  assign safe_out       = safe_r;
  assign error_out      = err_r;

  AST_FILTER_SPAN: assert property (@(posedge pclk) disable iff (!presetn)
    filter_r >= `SIE_FILTER_MIN && filter_r <= `SIE_FILTER_MAX)
    else $error("filter outside legal span");

  AST_SIMUL_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
    simul_act && mis && mis_cnt_r > simul_r |=> simul_flt_r ##1 !safe_r)
    else $error("overlong mismatch not flagged");

  AST_SIMUL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !simul_act && !short_set && !fault_any |=> !simul_flt_r)
    else $error("simultaneity fault while check off");

  AST_NO_RESET_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == sie_st_off && cond && !rst_en && !fault_any |=> st_r == sie_st_on ##0 safe_r)
    else $error("output did not follow input without reset");

  AST_MANUAL_RST: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == sie_st_wait_rst && !rst_mon && rst_rise && cond && !fault_any
    |=> safe_r)
    else $error("manual reset edge not accepted");

  AST_MON_RST: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == sie_st_wait_rst && rst_mon && !rst_armed_r |=> !safe_r)
    else $error("monitored reset accepted without prior rise");

  AST_COND_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !cond |=> !safe_r)
    else $error("output high with condition false");

  AST_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == sie_st_start && start_en && !seen_off_r |=> !safe_r)
    else $error("output enabled before start-up test");

  AST_CURTAIN_NO_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    is_curt |=> test_pulse_out == 2'h3)
    else $error("test pulse driven in curtain mode");

  AST_CURTAIN_SIMUL: assert property (@(posedge pclk) disable iff (!presetn)
    is_curt |-> simul_act)
    else $error("curtain interval check disabled");

  AST_ERR_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    err_en && fault_any && !clr_ok |=> error_out)
    else $error("fault not shown on error output");

  AST_FAULT_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    fault_any |=> !safe_r)
    else $error("output high during fault");

  COV_RESET_ON: cover property (@(posedge pclk) disable iff (!presetn)
    st_r == sie_st_wait_rst ##1 st_r == sie_st_on);
  COV_SIMUL: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(simul_flt_r));
  COV_SHORT: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(short_flt_r));

endmodule : sie_top

// ==== test/sie_contact_model.sv ====
`timescale 1ns/100ps
module sie_contact_model (
  input  wire logic       act_a,
  input  wire logic       act_b,
  input  wire logic       invert_b,
  input  wire logic       short_a,
  input  wire logic       pulse_en,
  input  wire logic [1:0] test_pulse_out,
  output logic            first_contact_input,
  output logic            second_contact_input
);
  logic [1:0] src;
  assign src = pulse_en ? test_pulse_out : 2'h3;
  // NO first; second is NC only while invert_b is set
  // A short to the supply holds the first line high whatever the contact does
  assign first_contact_input  = short_a | (act_a & src[0]);
  assign second_contact_input = (invert_b ? ~act_b : act_b) & src[1];
endmodule : sie_contact_model

// ==== test/safety_input_evaluator_tb.sv ====
`timescale 1ns/100ps
`include "sie_consts.svh"
module safety_input_evaluator_tb;
  import sie_pkg::*;
  localparam logic [12:0] RST = 13'h40, MON = 13'h80, STRT = 13'h100;
  localparam logic [12:0] SIM = 13'h200, ERR = 13'h400, TST = 13'h800;
  localparam int          LIM = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, v;
  logic        rerr, act_a, act_b, invert_b, short_a, pulse_en;
  // reset button on the input after the contacts
  logic        reset_input;
  logic        first_contact_input, second_contact_input, safe_out, error_out;
  logic [1:0]  test_pulse_out;
  logic [7:0]  corner [4];
  int          n_errors, n_compared, seed, k, cnt;
  logic [2:0]  tm [8], tt [8];

  sie_top #(.CYCLES_PER_MS(4), .ADDR_W(8), .PULSE_PERIOD_MS(4)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_contact_input(first_contact_input), .second_contact_input(second_contact_input),
    .reset_input(reset_input), .test_pulse_out(test_pulse_out), .safe_out(safe_out),
    .error_out(error_out));

  sie_contact_model partner (
    .act_a(act_a), .act_b(act_b), .invert_b(invert_b), .short_a(short_a),
    .pulse_en(pulse_en), .test_pulse_out(test_pulse_out),
    .first_contact_input(first_contact_input), .second_contact_input(second_contact_input));

  always #20 pclk = ~pclk;

  task close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 50);
    if (i >= 50) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle

  task drive(input logic a, input logic b);
    @(posedge pclk);
    act_a <= a;
    act_b <= b;
  endtask : drive

  task wait_for(input bit sel, input logic exp, input int lim);
    int i;
    i = 0;
    while (((sel ? error_out : safe_out) !== exp) && i < lim) begin
      @(posedge pclk);
      i++;
    end
  endtask : wait_for

  // Stops the block, parks the contacts at pre, then starts it with c
  task cfg(input logic [12:0] c, input logic pre);
    drive(1'h0, 1'h0);
    short_a  <= 1'h0;
    pulse_en <= c[11];
    settle(40);
    apb(1'h1, `SIE_CTRL_OFF, 32'h0);
    invert_b <= (c[5:3] == sie_it_ncno) && (c[2:0] != sie_mode_curtain);
    drive(pre, pre);
    settle(40);
    apb(1'h1, `SIE_CTRL_OFF, {19'h0, c});
  endtask : cfg

  function logic [12:0] mk(input logic [2:0] m, input logic [2:0] t, input logic [12:0] f);
    return f | {7'h0, t, m} | (13'h1 << `SIE_CTRL_RUN);
  endfunction : mk

  function logic [31:0] clamp_f(input logic [7:0] x);
    if (x < `SIE_FILTER_MIN) return {24'h0, `SIE_FILTER_MIN};
    if (x > `SIE_FILTER_MAX) return {24'h0, `SIE_FILTER_MAX};
    return {24'h0, x};
  endfunction : clamp_f

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  initial begin
    seed = 32'h089B8A6F;
    pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h0; pwdata = 32'h0; reset_input = 1'h0; act_a = 1'h0; act_b = 1'h0;
    invert_b = 1'h0; short_a = 1'h0; pulse_en = 1'h0;
    corner = '{8'h02, 8'h03, 8'hFA, 8'hFB};
    tm = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h0};
    tt = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1};
    settle(20);
    presetn <= 1'h1;
    apb(1'h0, `SIE_FILTER_OFF, 32'h0);
    check("filter_reset", rdat, 32'hA);
    apb(1'h0, `SIE_SIMUL_OFF, 32'h0);
    check("simul_reset", rdat, 32'h64);
    apb(1'h0, 8'h10, 32'h0);
    check("unmapped_err", {31'h0, rerr}, 32'h1);
    for (k = 0; k < 8; k++) begin
      v = (k < 4) ? {24'h0, corner[k]} : $random(seed);
      apb(1'h1, `SIE_FILTER_OFF, v);
      apb(1'h0, `SIE_FILTER_OFF, 32'h0);
      check("filter_clamp", rdat, clamp_f(v[7:0]));
    end
    apb(1'h1, `SIE_FILTER_OFF, 32'h3);
    apb(1'h1, `SIE_SIMUL_OFF, 32'h4);
    for (k = 0; k < 8; k++) begin
      cfg(mk(tm[k], tt[k], 13'h0), 1'h0);
      drive(1'h1, 1'h1);
      wait_for(1'h0, 1'h1, LIM);
      check("follow_on", {31'h0, safe_out}, 32'h1);
      drive(1'h0, 1'h0);
      wait_for(1'h0, 1'h0, LIM);
      check("follow_off", {31'h0, safe_out}, 32'h0);
    end
    // Bounce shorter than the filter must not reach the output
    drive(1'h1, 1'h1);
    settle(6);
    drive(1'h0, 1'h0);
    settle(30);
    check("bounce", {31'h0, safe_out}, 32'h0);
    cfg(mk(3'h1, 3'h0, RST), 1'h0);
    drive(1'h1, 1'h1);
    settle(40);
    check("needs_reset", {31'h0, safe_out}, 32'h0);
    reset_input <= 1'h1;
    wait_for(1'h0, 1'h1, LIM);
    check("manual_reset", {31'h0, safe_out}, 32'h1);
    reset_input <= 1'h0;
    settle(30);
    drive(1'h0, 1'h0);
    settle(40);
    drive(1'h1, 1'h1);
    settle(40);
    check("reset_again", {31'h0, safe_out}, 32'h0);
    cfg(mk(3'h1, 3'h0, RST | MON), 1'h0);
    drive(1'h1, 1'h1);
    settle(40);
    reset_input <= 1'h1;
    settle(40);
    check("monitored_rise", {31'h0, safe_out}, 32'h0);
    reset_input <= 1'h0;
    wait_for(1'h0, 1'h1, LIM);
    check("monitored_fall", {31'h0, safe_out}, 32'h1);
    for (k = 0; k < 2; k++) begin
      // Start-up test is armed by power-on only, so each pass starts from reset
      @(posedge pclk);
      presetn <= 1'h0;
      settle(2);
      presetn <= 1'h1;
      apb(1'h0, `SIE_FILTER_OFF, 32'h0);
      check("filter_rerst", rdat, 32'hA);
      apb(1'h1, `SIE_FILTER_OFF, 32'h3);
      apb(1'h1, `SIE_SIMUL_OFF, 32'h4);
      cfg(mk(k ? 3'h4 : 3'h1, 3'h1, STRT), 1'h1);
      settle(40);
      check("startup_hold", {31'h0, safe_out}, 32'h0);
      drive(1'h0, 1'h0);
      settle(40);
      drive(1'h1, 1'h1);
      wait_for(1'h0, 1'h1, LIM);
      check("startup_done", {31'h0, safe_out}, 32'h1);
    end
    cfg(mk(3'h0, 3'h1, SIM | ERR), 1'h0);
    drive(1'h1, 1'h0);
    settle(8);
    drive(1'h1, 1'h1);
    wait_for(1'h0, 1'h1, LIM);
    check("skew_ok", {30'h0, error_out, safe_out}, 32'h1);
    drive(1'h0, 1'h0);
    settle(40);
    drive(1'h1, 1'h0);
    wait_for(1'h1, 1'h1, LIM);
    check("simul_err", {30'h0, error_out, safe_out}, 32'h2);
    apb(1'h0, `SIE_STATUS_OFF, 32'h0);
    check("simul_flag", {31'h0, rdat[2]}, 32'h1);
    drive(1'h0, 1'h0);
    wait_for(1'h1, 1'h0, LIM);
    check("fault_clear", {30'h0, error_out, safe_out}, 32'h0);
    cfg(mk(3'h4, 3'h1, ERR), 1'h0);
    drive(1'h1, 1'h0);
    wait_for(1'h1, 1'h1, LIM);
    check("curtain_simul", {31'h0, error_out}, 32'h1);
    cfg(mk(3'h1, 3'h0, TST | ERR), 1'h0);
    drive(1'h1, 1'h1);
    wait_for(1'h0, 1'h1, LIM);
    settle(40);
    check("pulse_clean", {30'h0, error_out, safe_out}, 32'h1);
    drive(1'h0, 1'h0);
    short_a <= 1'h1;
    wait_for(1'h1, 1'h1, LIM);
    // The output drops one state step after the error shows
    settle(2);
    check("short_err", {30'h0, error_out, safe_out}, 32'h2);
    cfg(mk(3'h4, 3'h1, TST), 1'h1);
    cnt = 0;
    repeat (40) begin
      @(posedge pclk);
      if (test_pulse_out !== 2'h3) cnt++;
    end
    check("curtain_no_pulse", cnt, 32'h0);
    close_out();
  end
endmodule : safety_input_evaluator_tb
